//--- verilog/rtc_pkg.sv
// Purpose: Constants for the periodic real-time counter
// Assumes: One 10 MHz system clock; source clocks arrive as sync levels
// Notes:   Register indices are local to this block
// What this block does
// - Source select 00 low-power osc, 01 external ref, 1x internal ref.
// - Writing a different source select clears prescaler and count.
// - Writing a different divider select clears prescaler and count.
// - Divider select zero holds prescaler off; nonzero starts it.
// - Codes 1-7 divide by 2^3,2^5..2^10 or 2^10..2^16 by source bit 0.
// - Codes 8-15 give decimal-style ratios selected by source bit 0.
// - Count advances per prescaler period, wraps to zero after the limit.
// - Match flag sets when count goes from limit back to zero.
// - With limit zero the flag sets on every prescaler output pulse.
// - Writing one clears the flag and request; zero leaves it.
// - Interrupt requested when flag set and enable set; else polling.
// - Writing the match limit stores it and clears prescaler and count.
// - Count register reads the live count and ignores writes.
// - Reset gives count zero, limit zero, prescaler off, flag clear, osc 00.
// - Debug freezes counting; resumes unless configuration was written.
// - Enabled counter keeps running in wait and its interrupt wakes.
// - Keeps counting in stop; deep stop only low-power osc runs.
package rtc_pkg;
	localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_COUNT_VALUE    = 2'h1;
	localparam logic [1:0] ADDR_MATCH_LIMIT    = 2'h2;
	localparam int         FLAG_BIT            = 7;
	localparam int         SRC_HI              = 6;
	localparam int         SRC_LO              = 5;
	localparam int         IRQ_EN_BIT          = 4;
	localparam int         DIV_HI              = 3;
	localparam logic [1:0] SRC_LOW_POWER       = 2'h0;
	localparam logic [1:0] SRC_EXTERNAL        = 2'h1;
	localparam logic [7:0] BYTE_ZERO           = 8'h00;
	localparam logic [3:0] DIV_OFF             = 4'h0;
	localparam int         PRESCALE_W          = 18;
endpackage

//--- verilog/rtc_prescaler.sv
// Purpose: Divide the selected source edge count by the coded ratio
// Assumes: src_tick_i is one cycle per source clock rising edge
// Notes:   Emits one-cycle tick_o on terminal count
`timescale 1ns/1ps
module rtc_prescaler #(
	parameter int WIDTH = rtc_pkg::PRESCALE_W
) (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic       clear_i,
	input  wire logic       run_i,
	input  wire logic       src_tick_i,
	input  wire logic       hi_range_i,
	input  wire logic [3:0] code_i,
	output logic            tick_o
);
	// Elaboration check: the widest ratio needs eighteen bits
	if (WIDTH < 18) begin : g_width_check
		$error("prescaler width too small for 2x10^5");
	end

	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic             tick;
	} state_type;
	state_type st_reg;
	state_type st_next;

	// Ratio table selected by code and source bit 0
	function automatic logic [WIDTH-1:0] ratio(input logic hi, input logic [3:0] c);
		logic [17:0] r;
		r = 18'h00001;
		case ({hi, c})
			5'h01: r = 18'h00008;
			5'h02: r = 18'h00020;
			5'h03: r = 18'h00040;
			5'h04: r = 18'h00080;
			5'h05: r = 18'h00100;
			5'h06: r = 18'h00200;
			5'h07: r = 18'h00400;
			5'h08: r = 18'h00001;
			5'h09: r = 18'h00002;
			5'h0A: r = 18'h00004;
			5'h0B: r = 18'h0000A;
			5'h0C: r = 18'h00010;
			5'h0D: r = 18'h00064;
			5'h0E: r = 18'h001F4;
			5'h0F: r = 18'h003E8;
			5'h11: r = 18'h00400;
			5'h12: r = 18'h00800;
			5'h13: r = 18'h01000;
			5'h14: r = 18'h02000;
			5'h15: r = 18'h04000;
			5'h16: r = 18'h08000;
			5'h17: r = 18'h10000;
			5'h18: r = 18'h003E8;
			5'h19: r = 18'h007D0;
			5'h1A: r = 18'h01388;
			5'h1B: r = 18'h02710;
			5'h1C: r = 18'h04E20;
			5'h1D: r = 18'h0C350;
			5'h1E: r = 18'h186A0;
			5'h1F: r = 18'h30D40;
			default: r = 18'h00001;
		endcase
		return WIDTH'(r);
	endfunction

	// Count source edges, wrap at ratio
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (clear_i || code_i == rtc_pkg::DIV_OFF) begin
			st_next.cnt = '0;
		end else if (run_i && src_tick_i) begin
			if (st_next.cnt == ratio(hi_range_i, code_i) - WIDTH'(1)) begin
				st_next.cnt  = '0;
				st_next.tick = 1'b1;
			end else begin
				st_next.cnt = st_reg.cnt + WIDTH'(1);
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) st_reg <= '0;
		else st_reg <= st_next;
	end

	assign tick_o = st_reg.tick;

	property p_no_tick_when_off;
		@(posedge sys_clk_i) disable iff (rst_i)
		(code_i == rtc_pkg::DIV_OFF) |=> !st_reg.tick;
	endproperty
	a_no_tick_when_off: assert property (p_no_tick_when_off)
		else $error("prescaler ticked while off");
endmodule // rtc_prescaler

//--- verilog/rtc_counter.sv
// Purpose: Periodic real-time counter with match flag and interrupt
// Assumes: Source clocks sampled as synchronous levels; strobes one cycle
// Notes:   Read data valid the cycle after the read strobe only
//
// Design decisions made here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module rtc_counter (
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	input  wire logic [1:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	input  wire logic       low_power_osc_clock_i,
	input  wire logic       external_ref_clock_i,
	input  wire logic       internal_ref_clock_i,
	input  wire logic       debug_active_i,
	input  wire logic       deep_stop_i,
	output logic [7:0]      rdata_o,
	output logic            irq_o
);
	typedef struct packed {
		logic [1:0] source_select;
		logic [3:0] divider_select;
		logic       match_irq_enable;
		logic       match_flag;
		logic [7:0] count_value;
		logic [7:0] match_limit;
		logic [7:0] rdata;
		logic       irq;
		logic       src_last;
	} state_type;
	state_type st_reg;
	state_type st_next;

	logic src_level;
	logic src_tick;
	logic pre_tick;
	logic cfg_clear;
	logic wr_sc;
	logic wr_lim;

	////////////////////////////////////////////////////////////////////////
	// Level of the clock that a select code routes to the prescaler
	function automatic logic source_level(
		input logic [1:0] sel,
		input logic       low_power_osc_clock,
		input logic       ext,
		input logic       irc,
		input logic       deep
	);
		logic lvl;
		if (sel == rtc_pkg::SRC_LOW_POWER) begin
			lvl = low_power_osc_clock;
		end else if (sel == rtc_pkg::SRC_EXTERNAL) begin
			lvl = ext & ~deep;
		end else begin
			lvl = irc & ~deep;
		end
		return lvl;
	endfunction

	// Source selection and edge detection
	always_comb begin
		src_level = source_level(st_reg.source_select, low_power_osc_clock_i,
			external_ref_clock_i, internal_ref_clock_i, deep_stop_i);
	end
	// Wait and stop do not gate the counter: it runs on the source alone
	assign src_tick = src_level & ~st_reg.src_last;

	// Config writes that clear prescaler and count
	assign wr_sc  = wr_i && addr_i == rtc_pkg::ADDR_STATUS_CONTROL;
	assign wr_lim = wr_i && addr_i == rtc_pkg::ADDR_MATCH_LIMIT;
	assign cfg_clear = wr_lim
		|| (wr_sc && wdata_i[rtc_pkg::SRC_HI:rtc_pkg::SRC_LO] != st_reg.source_select)
		|| (wr_sc && wdata_i[rtc_pkg::DIV_HI:0] != st_reg.divider_select);

	rtc_prescaler #(
		.WIDTH(rtc_pkg::PRESCALE_W)
	) u_prescaler (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.clear_i   (cfg_clear),
		.run_i     (~debug_active_i),
		.src_tick_i(src_tick),
		.hi_range_i(st_reg.source_select[0]),
		.code_i    (st_reg.divider_select),
		.tick_o    (pre_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Next state: registers, counter, flag
	always_comb begin
		st_next = st_reg;
		if (cfg_clear) begin
			st_next.count_value = rtc_pkg::BYTE_ZERO;
		end else if (pre_tick && !debug_active_i) begin
			if (st_reg.count_value == st_reg.match_limit) begin
				st_next.count_value = rtc_pkg::BYTE_ZERO;
			end else begin
				st_next.count_value = st_reg.count_value + 8'h01;
			end
		end
		if (wr_sc) begin
			st_next.source_select    = wdata_i[rtc_pkg::SRC_HI:rtc_pkg::SRC_LO];
			st_next.match_irq_enable = wdata_i[rtc_pkg::IRQ_EN_BIT];
			st_next.divider_select   = wdata_i[rtc_pkg::DIV_HI:0];
			if (wdata_i[rtc_pkg::FLAG_BIT]) st_next.match_flag = 1'b0;
		end
		if (wr_lim) st_next.match_limit = wdata_i;
		// Reload the edge detector from the newly routed clock: a switch is no edge
		st_next.src_last = source_level(st_next.source_select, low_power_osc_clock_i,
			external_ref_clock_i, internal_ref_clock_i, deep_stop_i);
		// Set wins over a same-cycle clear
		if (!cfg_clear && pre_tick && !debug_active_i
			&& st_reg.count_value == st_reg.match_limit) begin
			st_next.match_flag = 1'b1;
		end
		st_next.irq = st_next.match_flag & st_next.match_irq_enable;
		st_next.rdata = rtc_pkg::BYTE_ZERO;
		if (rd_i) begin
			if (addr_i == rtc_pkg::ADDR_STATUS_CONTROL) begin
				st_next.rdata = {st_reg.match_flag, st_reg.source_select,
					st_reg.match_irq_enable, st_reg.divider_select};
			end else if (addr_i == rtc_pkg::ADDR_COUNT_VALUE) begin
				st_next.rdata = st_reg.count_value;
			end else if (addr_i == rtc_pkg::ADDR_MATCH_LIMIT) begin
				st_next.rdata = st_reg.match_limit;
			end
		end
	end

	// State register, reset to documented defaults
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) st_reg <= '0;
		else st_reg <= st_next;
	end

	assign rdata_o = st_reg.rdata;
	assign irq_o   = st_reg.irq;

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_wrap;
		@(posedge sys_clk_i) disable iff (rst_i)
		(pre_tick && !debug_active_i && !cfg_clear
			&& st_reg.count_value == st_reg.match_limit)
		|=> (st_reg.count_value == 8'h00 && st_reg.match_flag);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("no wrap or flag at match");

	property p_step;
		@(posedge sys_clk_i) disable iff (rst_i)
		(pre_tick && !debug_active_i && !cfg_clear
			&& st_reg.count_value != st_reg.match_limit)
		|=> st_reg.count_value == $past(st_reg.count_value) + 8'h01;
	endproperty
	a_step: assert property (p_step)
		else $error("count did not step");

	property p_limit_clear;
		@(posedge sys_clk_i) disable iff (rst_i)
		wr_lim |=> (st_reg.count_value == 8'h00 && st_reg.match_limit == $past(wdata_i));
	endproperty
	a_limit_clear: assert property (p_limit_clear)
		else $error("limit write did not clear count");

	property p_src_clear;
		@(posedge sys_clk_i) disable iff (rst_i)
		(wr_sc && wdata_i[rtc_pkg::SRC_HI:rtc_pkg::SRC_LO] != st_reg.source_select)
		|=> st_reg.count_value == 8'h00;
	endproperty
	a_src_clear: assert property (p_src_clear)
		else $error("source change did not clear count");

	property p_div_clear;
		@(posedge sys_clk_i) disable iff (rst_i)
		(wr_sc && wdata_i[rtc_pkg::DIV_HI:0] != st_reg.divider_select)
		|=> st_reg.count_value == 8'h00;
	endproperty
	a_div_clear: assert property (p_div_clear)
		else $error("divider change did not clear count");

	property p_flag_clear;
		@(posedge sys_clk_i) disable iff (rst_i)
		(wr_sc && wdata_i[rtc_pkg::FLAG_BIT] && !pre_tick) |=> !st_reg.match_flag;
	endproperty
	a_flag_clear: assert property (p_flag_clear)
		else $error("flag not cleared by one");

	property p_irq_level;
		@(posedge sys_clk_i) disable iff (rst_i)
		(st_reg.match_flag && st_reg.match_irq_enable) |-> irq_o;
	endproperty
	a_irq_level: assert property (p_irq_level)
		else $error("irq low while flag and enable set");

	property p_irq_gate;
		@(posedge sys_clk_i) disable iff (rst_i)
		!st_reg.match_irq_enable |-> !irq_o;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("irq while disabled");

	property p_freeze;
		@(posedge sys_clk_i) disable iff (rst_i)
		(debug_active_i && !cfg_clear) |=> $stable(st_reg.count_value);
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("count moved during debug");

	property p_read_count;
		@(posedge sys_clk_i) disable iff (rst_i)
		(rd_i && addr_i == rtc_pkg::ADDR_COUNT_VALUE)
		|=> rdata_o == $past(st_reg.count_value);
	endproperty
	a_read_count: assert property (p_read_count)
		else $error("count read mismatch");

	////////////////////////////////////////////////////////////////////////
	// Checks built from named steps
	localparam logic [3:0] DIV_UNITY = 4'h8; // Low-range code that divides by one

	// A prescaler tick the counter is free to take
	sequence s_live_tick;
		pre_tick && !debug_active_i && !cfg_clear;
	endsequence

	// A free tick while the limit is zero
	sequence s_zero_limit_tick;
		pre_tick && !debug_active_i && !cfg_clear
			&& st_reg.match_limit == rtc_pkg::BYTE_ZERO;
	endsequence

	// Flag up with the count back at zero
	sequence s_flag_at_zero;
		st_reg.match_flag && st_reg.count_value == rtc_pkg::BYTE_ZERO;
	endsequence

	property p_limit_zero;
		@(posedge sys_clk_i) disable iff (rst_i)
		s_zero_limit_tick |=> s_flag_at_zero;
	endproperty
	a_limit_zero: assert property (p_limit_zero)
		else $error("zero limit tick left flag clear");

	// Any live tick moves the count unless it wraps at zero; nothing gates it in wait
	property p_keeps_running;
		@(posedge sys_clk_i) disable iff (rst_i)
		s_live_tick |=> (st_reg.count_value != $past(st_reg.count_value)
			|| st_reg.count_value == rtc_pkg::BYTE_ZERO);
	endproperty
	a_keeps_running: assert property (p_keeps_running)
		else $error("live tick did not move the count");

	// No tick and no clearing write: the count holds
	property p_idle_hold;
		@(posedge sys_clk_i) disable iff (rst_i)
		(!pre_tick && !cfg_clear) |=> $stable(st_reg.count_value);
	endproperty
	a_idle_hold: assert property (p_idle_hold)
		else $error("count moved without a tick");

	// Divider off: no tick reaches the count
	property p_off_hold;
		@(posedge sys_clk_i) disable iff (rst_i)
		(st_reg.divider_select == rtc_pkg::DIV_OFF && !cfg_clear)
		|=> $stable(st_reg.count_value);
	endproperty
	a_off_hold: assert property (p_off_hold)
		else $error("count moved with divider off");

	// Unity ratio: every counted source edge gives a tick one cycle on
	sequence s_unity_edge;
		src_tick && !debug_active_i && !cfg_clear
			&& st_reg.divider_select == DIV_UNITY && !st_reg.source_select[0];
	endsequence

	property p_unity_tick;
		@(posedge sys_clk_i) disable iff (rst_i)
		s_unity_edge |=> pre_tick;
	endproperty
	a_unity_tick: assert property (p_unity_tick)
		else $error("unity ratio missed a tick");

	// Flag can only rise on a match step
	sequence s_flag_idle;
		!st_reg.match_flag && !(pre_tick && !debug_active_i && !cfg_clear
			&& st_reg.count_value == st_reg.match_limit);
	endsequence

	property p_flag_no_stray;
		@(posedge sys_clk_i) disable iff (rst_i)
		s_flag_idle |=> !st_reg.match_flag;
	endproperty
	a_flag_no_stray: assert property (p_flag_no_stray)
		else $error("flag set without a match");

	// A set flag stays until a one is written to it
	property p_flag_sticky;
		@(posedge sys_clk_i) disable iff (rst_i)
		(st_reg.match_flag && !(wr_sc && wdata_i[rtc_pkg::FLAG_BIT]))
		|=> st_reg.match_flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky)
		else $error("flag dropped without a clear");

	// Writing one with no match pending withdraws the request
	sequence s_clear_write;
		wr_sc && wdata_i[rtc_pkg::FLAG_BIT] && !pre_tick;
	endsequence

	property p_irq_withdraw;
		@(posedge sys_clk_i) disable iff (rst_i)
		s_clear_write |=> !irq_o;
	endproperty
	a_irq_withdraw: assert property (p_irq_withdraw)
		else $error("request stayed after flag clear");

	// A write aimed at the count register leaves the count alone
	property p_count_ro;
		@(posedge sys_clk_i) disable iff (rst_i)
		(wr_i && addr_i == rtc_pkg::ADDR_COUNT_VALUE && !pre_tick)
		|=> $stable(st_reg.count_value);
	endproperty
	a_count_ro: assert property (p_count_ro)
		else $error("count write took effect");

	// Deep stop with a gated source for two cycles: the count holds
	sequence s_deep_gated;
		(deep_stop_i && st_reg.source_select != rtc_pkg::SRC_LOW_POWER && !wr_i)[*2];
	endsequence

	property p_deep_hold;
		@(posedge sys_clk_i) disable iff (rst_i)
		s_deep_gated |=> $stable(st_reg.count_value);
	endproperty
	a_deep_hold: assert property (p_deep_hold)
		else $error("gated source counted in deep stop");

	// Match limit reads back as stored
	property p_read_limit;
		@(posedge sys_clk_i) disable iff (rst_i)
		(rd_i && addr_i == rtc_pkg::ADDR_MATCH_LIMIT)
		|=> rdata_o == $past(st_reg.match_limit);
	endproperty
	a_read_limit: assert property (p_read_limit)
		else $error("limit read mismatch");

	// Status fields read back in their bit positions
	property p_read_status;
		@(posedge sys_clk_i) disable iff (rst_i)
		(rd_i && addr_i == rtc_pkg::ADDR_STATUS_CONTROL)
		|=> (rdata_o[rtc_pkg::FLAG_BIT] == $past(st_reg.match_flag)
			&& rdata_o[rtc_pkg::SRC_HI:rtc_pkg::SRC_LO] == $past(st_reg.source_select)
			&& rdata_o[rtc_pkg::IRQ_EN_BIT] == $past(st_reg.match_irq_enable)
			&& rdata_o[rtc_pkg::DIV_HI:0] == $past(st_reg.divider_select));
	endproperty
	a_read_status: assert property (p_read_status)
		else $error("status read mismatch");
endmodule // rtc_counter

//--- sim/rtc_counter_tb_top.sv
// Purpose: Self-checking bench for the periodic real-time counter
// Assumes: Source clocks are pulsed slowly against the 10 MHz clock
// Notes:   Model tracks prescaler phase, count, flag and enable
`timescale 1ns/1ps
module rtc_counter_tb_top;
	logic        sys_clk_i;
	logic        rst_i;
	logic [1:0]  addr_i;
	logic [7:0]  wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [2:0]  src_clk;
	logic        debug_active_i;
	logic        deep_stop_i;
	logic [7:0]  rdata_o;
	logic        irq_o;
	int          error_cnt;
	int          total_checks;
	int          cycle_cnt;
	int          m_src, m_div, m_lim, m_cnt, m_pre, m_flag, m_ien;
	int unsigned seed_v;

	rtc_counter dut (
		.sys_clk_i             (sys_clk_i),
		.rst_i                 (rst_i),
		.addr_i                (addr_i),
		.wdata_i               (wdata_i),
		.wr_i                  (wr_i),
		.rd_i                  (rd_i),
		.low_power_osc_clock_i (src_clk[0]),
		.external_ref_clock_i  (src_clk[1]),
		.internal_ref_clock_i  (src_clk[2]),
		.debug_active_i        (debug_active_i),
		.deep_stop_i           (deep_stop_i),
		.rdata_o               (rdata_o),
		.irq_o                 (irq_o)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end

	always @(posedge sys_clk_i) begin
		cycle_cnt <= cycle_cnt + 1;
		if (cycle_cnt == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Helpers
	task automatic conclude();
		if (error_cnt == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Divide ratio per divider code, low and high range
	function automatic int ratio(input int hi, input int code);
		int lo_t[16] = '{0, 8, 32, 64, 128, 256, 512, 1024, 1, 2, 4, 10, 16, 100, 500, 1000};
		int hi_t[16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536, 1000, 2000,
			5000, 10000, 20000, 50000, 100000, 200000};
		return hi ? hi_t[code] : lo_t[code];
	endfunction

	function automatic logic [7:0] stat();
		return 8'(m_flag * 128 + m_src * 32 + m_ien * 16 + m_div);
	endfunction

	// One register write, model follows
	task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge sys_clk_i);
		wr_i <= 1'b0;
		if (a == rtc_pkg::ADDR_STATUS_CONTROL) begin
			if (int'(d[6:5]) != m_src || int'(d[3:0]) != m_div) begin
				m_cnt = 0;
				m_pre = 0;
			end
			m_src = d[6:5];
			m_div = d[3:0];
			m_ien = d[4];
			if (d[7])
				m_flag = 0;
		end else if (a == rtc_pkg::ADDR_MATCH_LIMIT) begin
			m_lim = d;
			m_cnt = 0;
			m_pre = 0;
		end
		repeat (2) @(posedge sys_clk_i);
	endtask

	// One read, data sampled in the cycle after the strobe
	task automatic rd_chk(input logic [1:0] a, input logic [7:0] e);
		@(posedge sys_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge sys_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(rdata_o, e);
	endtask

	// Rising edges on one source clock, model counts the selected one
	task automatic pulse(input int which, input int num);
		for (int i = 0; i < num; i++) begin
			@(posedge sys_clk_i);
			src_clk[which] <= 1'b1;
			repeat (2) @(posedge sys_clk_i);
			src_clk[which] <= 1'b0;
			repeat (2) @(posedge sys_clk_i);
			if (which == ((m_src > 1) ? 2 : m_src) && m_div != 0 && !debug_active_i
				&& !(deep_stop_i && m_src != 0)) begin
				m_pre++;
				if (m_pre >= ratio(m_src % 2, m_div)) begin
					m_pre = 0;
					m_flag = (m_cnt == m_lim) ? 1 : m_flag;
					m_cnt = (m_cnt == m_lim) ? 0 : m_cnt + 1;
				end
			end
		end
		repeat (4) @(posedge sys_clk_i);
	endtask

	task automatic all_chk();
		rd_chk(2'h1, 8'(m_cnt));
		rd_chk(2'h0, stat());
		chk({7'h00, irq_o}, 8'(m_flag & m_ien));
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_i = 1'b1;
		addr_i = 2'h0;
		wdata_i = 8'h00;
		wr_i = 1'b0;
		rd_i = 1'b0;
		src_clk = 3'h0;
		debug_active_i = 1'b0;
		deep_stop_i = 1'b0;
		seed_v = $urandom(32'h4E44);
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		all_chk();
		rd_chk(2'h2, 8'h00);
		rd_chk(2'h3, 8'h00);
		pulse(0, 3);
		all_chk();
		reg_wr(2'h2, 8'h03);
		reg_wr(2'h0, 8'h18);
		pulse(0, 10);
		all_chk();
		reg_wr(2'h0, 8'h18);
		all_chk();
		reg_wr(2'h1, 8'h55);
		all_chk();
		reg_wr(2'h0, 8'h98);
		all_chk();
		debug_active_i <= 1'b1;
		pulse(0, 5);
		all_chk();
		debug_active_i <= 1'b0;
		pulse(0, 1);
		all_chk();
		reg_wr(2'h0, 8'h38);
		pulse(0, 4);
		pulse(1, 5);
		all_chk();
		deep_stop_i <= 1'b1;
		pulse(1, 3);
		all_chk();
		deep_stop_i <= 1'b0;
		reg_wr(2'h2, 8'($urandom_range(20, 9)));
		reg_wr(2'h0, 8'h58);
		pulse(2, $urandom_range(8, 4));
		all_chk();
		reg_wr(2'h2, 8'($urandom_range(9, 1)));
		all_chk();
		pulse(2, 1);
		reg_wr(2'h0, 8'h51);
		pulse(2, 16 + $urandom_range(7, 0));
		all_chk();
		reg_wr(2'h0, 8'hD9);
		pulse(2, 7);
		all_chk();
		reg_wr(2'h2, 8'h00);
		reg_wr(2'h0, 8'hF1);
		pulse(2, 1023);
		all_chk();
		pulse(2, 1);
		all_chk();
		reg_wr(2'h0, 8'h61);
		all_chk();
		// Second reset in mid-run from a busy state
		@(posedge sys_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		m_src = 0;
		m_div = 0;
		m_lim = 0;
		m_cnt = 0;
		m_pre = 0;
		m_flag = 0;
		m_ien = 0;
		all_chk();
		rd_chk(2'h2, 8'h00);
		conclude();
	end
endmodule // rtc_counter_tb_top
